// ### common/fault_status_pkg.sv
// fault and status register constants: offsets, bit positions, resets, timing
// assumes a 10 MHz core clock and byte-wide register access
package fault_status_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] GEN_STATUS_ADDR     = 8'h02;
    localparam logic [7:0] RSVD_SLOT_ADDR      = 8'h04;
    localparam logic [7:0] PRIMARY_FAULT_ADDR  = 8'h05;
    localparam logic [7:0] SECOND_FAULT_ADDR   = 8'h06;
    localparam logic [7:0] RESULT_HIGH_ADDR    = 8'h07;
    localparam logic [7:0] RESULT_LOW_ADDR     = 8'h08;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int IRQ_RELEASE_BIT   = 7;
    localparam int IRQ_PIN_BIT       = 6;
    localparam int EN_PIN_BIT        = 5;
    localparam int LDO_FAULT_BIT     = 4;
    localparam int OVERTEMP_BIT      = 3;
    localparam int SWITCH_OC_BIT     = 2;
    localparam int WDOG_FAULT_BIT    = 7;
    localparam int HICCUP_BIT        = 6;
    localparam int INPUT_UV_BIT      = 5;
    localparam int OUTPUT_OV_BIT     = 4;
    localparam int LOWLOAD_BIT       = 3;
    localparam int INPUT_OV_BIT      = 2;
    localparam int BUS_ERR_BIT       = 1;
    localparam int RESULT_HI_LSB     = 6;

    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RESET_VAL   = 8'h00;
    localparam logic [1:0] MODE_POWER_ON   = 2'h2;
    localparam logic [2:0] CHAN_INVALID    = 3'h4;
    localparam logic [1:0] WDOG_OFF        = 2'h0;
    localparam logic [1:0] WDOG_80         = 2'h1;
    localparam logic [1:0] WDOG_160        = 2'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 100;
    localparam int MS_NS            = 1000000;
    localparam int TICK_CYCLES      = MS_NS / CLK_PERIOD_NS;
    localparam int LDO_RESTART_MS   = 100;
    localparam int HICCUP_S         = 3;
    localparam int HICCUP_MS        = HICCUP_S * 1000;
    localparam int WDOG_SHORT_S     = 80;
    localparam int WDOG_MID_S       = 160;
    localparam int WDOG_LONG_S      = 320;

endpackage

// ### hdl/fault_latch.sv
// bank of latching fault flags with read-to-clear
// set wins over clear; a flag whose hold input is high ignores the clear
`timescale 1ns/100ps
`default_nettype none

module fault_latch #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] hold_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output var  logic [WIDTH-1:0] flag_o
);

    logic [WIDTH-1:0] flag_ff;
    logic [WIDTH-1:0] nxt_flag;

    if (WIDTH < 1) begin : g_bad_width
        $error("fault_latch needs at least one flag");
    end

    always_comb begin
        nxt_flag = set_i | (flag_ff & ~(clr_i & ~hold_i));
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag_o = flag_ff;

endmodule // fault_latch

`default_nettype wire

// ### hdl/fault_status_registers.sv
// fault and status register group: flags, interrupt, watchdog, result bytes
// assumes a byte register port from the serial host decoder, one cycle strobes
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - writing 1 to bit 7 of 0x05 releases interrupt; bit reads 0
// - interrupt stays asserted after release while any unmasked fault except bus error and watchdog expiry is live
// - bit 6 of 0x02 shows live interrupt pin level
// - ldo overcurrent/undervoltage latches bit 4 of 0x05; mask ignored
// - ldo flag read-clear ignored during 100 ms restart delay
// - overtemp bit 3, switch overcurrent bit 2; read clears once gone
// - watchdog expiry sets bit 7 of 0x06; reads never clear it
// - host read or watchdog disable restarts watchdog timer
// - output hiccup sets bit 6 of 0x06
// - hiccup flag held for 3 s restart; read clears after hiccup
// - input undervoltage sets bit 5; read clears once input recovers
// - output overvoltage sets bit 4; read clears once below threshold
// - light-load disable sets bit 3; read clears after state left
// - input overvoltage in power-on sets bit 2; clears once below
// - bus command or data error sets bit 1 of 0x06
// - 0x07 holds selected result: bits 13:6 wide, 7:0 narrow
// - 0x08 holds low six bits of a wide result
// - 3-bit channel select picks result; code 100 invalid
// - 2-bit watchdog field: off, 80 s, 160 s, 320 s
module fault_status_registers
    import fault_status_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output var  logic [7:0]  reg_rdata_o,
    // open-drain interrupt pin
    input  wire logic        fault_irq_pin_i,
    output var  logic        fault_irq_n_o,
    output var  logic        fault_irq_oe_o,
    // live conditions
    input  wire logic        ldo_overcurrent_i,
    input  wire logic        ldo_undervolt_i,
    input  wire logic        ldo_fault_mask_i,
    input  wire logic        overtemp_i,
    input  wire logic        switch_overcurrent_i,
    input  wire logic        output_hiccup_i,
    input  wire logic        input_undervolt_i,
    input  wire logic        output_overvolt_i,
    input  wire logic        lowload_disabled_state_i,
    input  wire logic        input_overvolt_i,
    input  wire logic        bus_error_i,
    input  wire logic        en_pin_i,
    input  wire logic [1:0]  operation_mode_i,
    input  wire logic [1:0]  wdog_period_sel_i,
    // conversion results
    input  wire logic        conv_valid_i,
    input  wire logic [2:0]  conv_chan_i,
    input  wire logic [13:0] conv_data_i,
    input  wire logic        conv_wide_i,
    input  wire logic [2:0]  result_chan_sel_i
);

    localparam int WD_W = 19;
    localparam logic [WD_W-1:0] WD_80  = WD_W'(WDOG_SHORT_S * 1000);
    localparam logic [WD_W-1:0] WD_160 = WD_W'(WDOG_MID_S * 1000);
    localparam logic [WD_W-1:0] WD_320 = WD_W'(WDOG_LONG_S * 1000);
    localparam logic [6:0]  LDO_MS  = 7'(LDO_RESTART_MS);
    localparam logic [11:0] HIC_MS  = 12'(HICCUP_MS);

    if (TICK_LEN < 1 || TICK_LEN > 65535) begin : g_bad_tick
        $error("TICK_LEN must lie in 1..65535");
    end

    // ----------------------------------------------------------------
    // millisecond tick divider
    // ----------------------------------------------------------------
    logic [15:0] tick_cnt_ff;
    logic [15:0] nxt_tick_cnt;
    logic        tick;

    always_comb begin
        tick         = (tick_cnt_ff == 16'(TICK_LEN - 1));
        nxt_tick_cnt = tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_ff <= 16'h0000;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
        end
    end

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    logic rd_primary;
    logic rd_second;
    logic release_wr;

    always_comb begin
        rd_primary = reg_rd_i && (reg_addr_i == PRIMARY_FAULT_ADDR);
        rd_second  = reg_rd_i && (reg_addr_i == SECOND_FAULT_ADDR);
        release_wr = reg_wr_i && (reg_addr_i == PRIMARY_FAULT_ADDR)
                     && reg_wdata_i[IRQ_RELEASE_BIT];
    end

    // ----------------------------------------------------------------
    // watchdog, ldo restart and hiccup hold timers
    // ----------------------------------------------------------------
    logic [WD_W-1:0] wd_cnt_ff;
    logic [WD_W-1:0] nxt_wd_cnt;
    logic [WD_W-1:0] wd_limit;
    logic            wd_expire;
    logic [6:0]      ldo_cnt_ff;
    logic [6:0]      nxt_ldo_cnt;
    logic [11:0]     hic_cnt_ff;
    logic [11:0]     nxt_hic_cnt;
    logic            hic_prev_ff;

    always_comb begin
        case (wdog_period_sel_i)
            WDOG_80:  wd_limit = WD_80;
            WDOG_160: wd_limit = WD_160;
            default:  wd_limit = WD_320;
        endcase
        wd_expire  = 1'b0;
        nxt_wd_cnt = wd_cnt_ff;
        if (wdog_period_sel_i == WDOG_OFF || reg_rd_i) begin
            nxt_wd_cnt = '0;
        end else if (tick) begin
            if (wd_cnt_ff >= wd_limit - 1'b1) begin
                wd_expire  = 1'b1;
                nxt_wd_cnt = '0;
            end else begin
                nxt_wd_cnt = wd_cnt_ff + 1'b1;
            end
        end
        nxt_ldo_cnt = ldo_cnt_ff;
        if (ldo_overcurrent_i) begin
            nxt_ldo_cnt = LDO_MS;
        end else if (tick && ldo_cnt_ff != 7'h00) begin
            nxt_ldo_cnt = ldo_cnt_ff - 7'h01;
        end
        nxt_hic_cnt = hic_cnt_ff;
        if (output_hiccup_i && !hic_prev_ff) begin
            nxt_hic_cnt = HIC_MS;
        end else if (tick && hic_cnt_ff != 12'h000) begin
            nxt_hic_cnt = hic_cnt_ff - 12'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_cnt_ff   <= '0;
            ldo_cnt_ff  <= 7'h00;
            hic_cnt_ff  <= 12'h000;
            hic_prev_ff <= 1'b0;
        end else begin
            wd_cnt_ff   <= nxt_wd_cnt;
            ldo_cnt_ff  <= nxt_ldo_cnt;
            hic_cnt_ff  <= nxt_hic_cnt;
            hic_prev_ff <= output_hiccup_i;
        end
    end

    // ----------------------------------------------------------------
    // latching flags
    // ----------------------------------------------------------------
    logic [2:0] p_set;
    logic [2:0] p_hold;
    logic [2:0] p_flag;
    logic [6:0] s_set;
    logic [6:0] s_hold;
    logic [6:0] s_clr;
    logic [6:0] s_flag;
    logic       ldo_event;

    always_comb begin
        ldo_event = ldo_overcurrent_i | ldo_undervolt_i;
        // primary: index 2 ldo, 1 overtemp, 0 switch
        p_set  = {ldo_event, overtemp_i, switch_overcurrent_i};
        p_hold = {ldo_event || ldo_cnt_ff != 7'h00,
                  overtemp_i, switch_overcurrent_i};
        // secondary: index 6 watchdog .. index 0 bus error
        s_set  = {wd_expire,
                  output_hiccup_i,
                  input_undervolt_i,
                  output_overvolt_i,
                  lowload_disabled_state_i,
                  input_overvolt_i && operation_mode_i == MODE_POWER_ON,
                  bus_error_i};
        s_hold = {1'b1,
                  output_hiccup_i || hic_cnt_ff != 12'h000,
                  input_undervolt_i,
                  output_overvolt_i,
                  lowload_disabled_state_i,
                  input_overvolt_i,
                  1'b0};
        s_clr  = {7{rd_second}};
    end

    fault_latch #(.WIDTH(3)) u_primary (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .set_i     (p_set),
        .hold_i    (p_hold),
        .clr_i     ({3{rd_primary}}),
        .flag_o    (p_flag)
    );

    fault_latch #(.WIDTH(7)) u_second (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .set_i     (s_set),
        .hold_i    (s_hold),
        .clr_i     (s_clr),
        .flag_o    (s_flag)
    );

    // ----------------------------------------------------------------
    // interrupt pin
    // ----------------------------------------------------------------
    logic [9:0] all_flags_ff;
    logic [9:0] irq_src;
    logic       live_fault;
    logic       irq_ff;
    logic       irq_n_ff;
    logic       nxt_irq;

    always_comb begin
        irq_src    = {p_flag[2] & ~ldo_fault_mask_i, p_flag[1:0], s_flag};
        live_fault = (ldo_event & ~ldo_fault_mask_i) | overtemp_i
                     | switch_overcurrent_i | output_hiccup_i | input_undervolt_i
                     | output_overvolt_i | lowload_disabled_state_i
                     | s_set[1];
        nxt_irq = irq_ff;
        if (release_wr) begin
            nxt_irq = live_fault;
        end
        if ((irq_src & ~all_flags_ff) != 10'h000) begin
            nxt_irq = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_ff       <= 1'b0;
            irq_n_ff     <= 1'b1;
            all_flags_ff <= 10'h000;
        end else begin
            irq_ff       <= nxt_irq;
            irq_n_ff     <= ~nxt_irq;
            all_flags_ff <= irq_src;
        end
    end

    assign fault_irq_n_o  = irq_n_ff;
    assign fault_irq_oe_o = irq_ff;

    // ----------------------------------------------------------------
    // conversion results and read data
    // ----------------------------------------------------------------
    logic [13:0] result_mem [0:7];
    logic [13:0] sel_result;
    logic [7:0]  nxt_rdata;
    logic [7:0]  rdata_ff;

    always_ff @(posedge ref_clk_i) begin
        if (conv_valid_i) begin
            result_mem[conv_chan_i] <= conv_data_i;
        end
    end

    always_comb begin
        sel_result = (result_chan_sel_i == CHAN_INVALID) ? 14'h0000
                     : result_mem[result_chan_sel_i];
        nxt_rdata = REG_RESET_VAL;
        case (reg_addr_i)
            GEN_STATUS_ADDR: begin
                nxt_rdata[IRQ_PIN_BIT] = fault_irq_pin_i;
                nxt_rdata[EN_PIN_BIT]  = en_pin_i;
                nxt_rdata[1:0]         = operation_mode_i;
            end
            PRIMARY_FAULT_ADDR: begin
                nxt_rdata[LDO_FAULT_BIT] = p_flag[2];
                nxt_rdata[OVERTEMP_BIT]  = p_flag[1];
                nxt_rdata[SWITCH_OC_BIT] = p_flag[0];
            end
            SECOND_FAULT_ADDR: begin
                nxt_rdata[WDOG_FAULT_BIT:BUS_ERR_BIT] = s_flag;
            end
            RESULT_HIGH_ADDR: begin
                nxt_rdata = conv_wide_i ? sel_result[13:RESULT_HI_LSB]
                                        : sel_result[7:0];
            end
            RESULT_LOW_ADDR: begin
                nxt_rdata[RESULT_HI_LSB-1:0] = conv_wide_i
                    ? sel_result[RESULT_HI_LSB-1:0] : 6'h00;
            end
            default: nxt_rdata = REG_RESET_VAL;
        endcase
        if (!reg_rd_i) begin
            nxt_rdata = rdata_ff;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= REG_RESET_VAL;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    irq_release_a: assert property (
        release_wr && !live_fault && (irq_src & ~all_flags_ff) == 10'h000
        |=> !fault_irq_oe_o && fault_irq_n_o)
        else $error("interrupt not released");
    irq_stays_a: assert property (
        irq_ff && release_wr && live_fault |=> fault_irq_oe_o)
        else $error("interrupt dropped with live fault");
    pin_status_a: assert property (
        reg_rd_i && reg_addr_i == GEN_STATUS_ADDR
        |=> reg_rdata_o[IRQ_PIN_BIT] == $past(fault_irq_pin_i))
        else $error("pin status bit wrong");
    ldo_latch_a: assert property (
        ldo_event && ldo_fault_mask_i |=> p_flag[2])
        else $error("ldo flag not latched");
    ldo_hold_a: assert property (
        p_flag[2] && ldo_cnt_ff != 7'h00 && rd_primary |=> p_flag[2])
        else $error("ldo flag cleared in restart delay");
    overtemp_keep_a: assert property (
        p_flag[1] && overtemp_i && rd_primary |=> p_flag[1])
        else $error("overtemp flag cleared while present");
    wdog_sticky_a: assert property (
        s_flag[6] |=> s_flag[6])
        else $error("watchdog flag cleared");
    wdog_restart_a: assert property (
        reg_rd_i |=> wd_cnt_ff == '0)
        else $error("watchdog not restarted");
    hiccup_hold_a: assert property (
        $rose(output_hiccup_i) |=> s_flag[5] [*8])
        else $error("hiccup flag not held");
    bus_err_a: assert property (
        rd_second && s_flag[0] |=> reg_rdata_o[BUS_ERR_BIT])
        else $error("bus error flag missing");

endmodule // fault_status_registers

`default_nettype wire

// ### verif/host_model.sv
// host model: serial-side controller issuing byte register accesses
// assumes one-cycle strobes and read data one cycle after the read edge
`timescale 1ns/100ps
`default_nettype none

module host_model (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic [7:0] addr_o,
    output var  logic       wr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       rd_o
);
    initial begin
        addr_o  = 8'h00;
        wr_o    = 1'b0;
        wdata_o = 8'h00;
        rd_o    = 1'b0;
    end

    // ------------------------------------------------------------
    // one access: release writes and watchdog-restart reads
    // ------------------------------------------------------------
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] wd, output logic [7:0] rd);
        @(posedge ref_clk_i);
        addr_o  <= a;
        wdata_o <= wd;
        wr_o    <= w;
        rd_o    <= !w;
        @(posedge ref_clk_i);
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~wd;
        @(posedge ref_clk_i);
        rd = rdata_i;
    endtask
endmodule // host_model
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the fault and status register group
// assumes host_model drives the register port; tick shortened to one cycle
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import fault_status_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, oe, irq_n, ldo_oc = 0, ldo_uv = 0, ldo_mask = 0;
    logic [5:0] cond = '0;
    logic hic = 0, bus_err = 0, en = 0, cv = 0, cwide = 1;
    logic [1:0] mode = MODE_POWER_ON, wsel = WDOG_OFF;
    logic [2:0] cch = '0, csel = '0;
    logic [13:0] cdat = '0;
    logic [31:0] seed = 32'h1a62;
    int error_cnt = 0, n_checks = 0;
    wire pin = (oe === 1'b1) ? 1'b0 : 1'b1; // pull-up on open drain
    always #50 clk = ~clk;

    host_model i_host (.ref_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata), .rd_o(rd));

    fault_status_registers #(.TICK_LEN(1)) i_dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .fault_irq_pin_i(pin), .fault_irq_n_o(irq_n), .fault_irq_oe_o(oe),
        .ldo_overcurrent_i(ldo_oc), .ldo_undervolt_i(ldo_uv),
        .ldo_fault_mask_i(ldo_mask), .overtemp_i(cond[0]),
        .switch_overcurrent_i(cond[1]), .output_hiccup_i(hic),
        .input_undervolt_i(cond[2]), .output_overvolt_i(cond[3]),
        .lowload_disabled_state_i(cond[4]), .input_overvolt_i(cond[5]),
        .bus_error_i(bus_err), .en_pin_i(en), .operation_mode_i(mode),
        .wdog_period_sel_i(wsel), .conv_valid_i(cv), .conv_chan_i(cch),
        .conv_data_i(cdat), .conv_wide_i(cwide), .result_chan_sel_i(csel));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] flag_addr(int i);
        return (i < 2) ? PRIMARY_FAULT_ADDR : SECOND_FAULT_ADDR;
    endfunction

    function automatic logic [7:0] flag_mask(int i);
        int pos [6] = '{OVERTEMP_BIT, SWITCH_OC_BIT, INPUT_UV_BIT,
                        OUTPUT_OV_BIT, LOWLOAD_BIT, INPUT_OV_BIT};
        return 8'h01 << pos[i];
    endfunction

    task automatic chk(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdc(logic [7:0] a, logic [7:0] e);
        i_host.access(1'b0, a, 8'h00, d);
        chk(d, e);
    endtask

    task automatic wrr(logic [7:0] a, logic [7:0] v);
        i_host.access(1'b1, a, v, d);
    endtask

    task automatic close_out;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // live condition: latched, held while live, cleared once gone
    task automatic flag_case(int i);
        cond[i] <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(flag_addr(i), flag_mask(i));
        chk({7'h0, oe}, 8'h01);
        rdc(flag_addr(i), flag_mask(i));
        cond[i] <= 1'b0;
        rdc(flag_addr(i), flag_mask(i));
        rdc(flag_addr(i), 8'h00);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (cond[i]) begin
            rdc(RSVD_SLOT_ADDR - 8'h01 + 8'(i % 2), 8'h00);
        end
        rdc(8'h20, 8'h00);
        wrr(RSVD_SLOT_ADDR, 8'hff);
        wrr(SECOND_FAULT_ADDR, 8'hff);
        rdc(RSVD_SLOT_ADDR, 8'h00);
        rdc(SECOND_FAULT_ADDR, 8'h00);
        en <= 1'b1;
        rdc(GEN_STATUS_ADDR, 8'h62);
        for (int i = 0; i < 6; i++) begin
            flag_case(i);
        end
        // input overvoltage outside power-on must not latch
        mode <= 2'h0;
        cond[5] <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(SECOND_FAULT_ADDR, 8'h00);
        cond[5] <= 1'b0;
        mode <= MODE_POWER_ON;
        rdc(GEN_STATUS_ADDR, 8'h22);
        cond[0] <= 1'b1;
        wrr(PRIMARY_FAULT_ADDR, 8'h80);
        chk({6'h00, oe, irq_n}, 8'h02);
        cond[0] <= 1'b0;
        rdc(PRIMARY_FAULT_ADDR, 8'h08);
        rdc(PRIMARY_FAULT_ADDR, 8'h00);
        wrr(PRIMARY_FAULT_ADDR, 8'h80);
        chk({6'h00, oe, irq_n}, 8'h01);
        rdc(GEN_STATUS_ADDR, 8'h62);
        ldo_oc <= 1'b1;
        repeat (3) @(posedge clk);
        ldo_oc <= 1'b0;
        rdc(PRIMARY_FAULT_ADDR, 8'h10);
        repeat (50) @(posedge clk);
        rdc(PRIMARY_FAULT_ADDR, 8'h10);
        repeat (100) @(posedge clk);
        rdc(PRIMARY_FAULT_ADDR, 8'h10);
        rdc(PRIMARY_FAULT_ADDR, 8'h00);
        wrr(PRIMARY_FAULT_ADDR, 8'h80);
        ldo_mask <= 1'b1;
        ldo_uv <= 1'b1;
        repeat (3) @(posedge clk);
        ldo_uv <= 1'b0;
        chk({7'h0, oe}, 8'h00);
        rdc(PRIMARY_FAULT_ADDR, 8'h10);
        rdc(PRIMARY_FAULT_ADDR, 8'h00);
        bus_err <= 1'b1;
        @(posedge clk);
        bus_err <= 1'b0;
        rdc(SECOND_FAULT_ADDR, 8'h02);
        rdc(SECOND_FAULT_ADDR, 8'h00);
        hic <= 1'b1;
        repeat (5) @(posedge clk);
        hic <= 1'b0;
        rdc(SECOND_FAULT_ADDR, 8'h40);
        repeat (2900) @(posedge clk);
        rdc(SECOND_FAULT_ADDR, 8'h40);
        repeat (200) @(posedge clk);
        rdc(SECOND_FAULT_ADDR, 8'h40);
        rdc(SECOND_FAULT_ADDR, 8'h00);
        for (int w = 1; w >= 0; w--) begin
            cwide <= w[0];
            for (int ch = 0; ch < 8; ch++) begin
                seed = lfsr(seed);
                cdat <= seed[13:0];
                cch <= 3'(ch);
                csel <= 3'(ch);
                cv <= 1'b1;
                @(posedge clk);
                cv <= 1'b0;
                if (ch == 4) begin
                    rdc(RESULT_HIGH_ADDR, 8'h00);
                end else if (w == 1) begin
                    rdc(RESULT_HIGH_ADDR, seed[13:6]);
                    rdc(RESULT_LOW_ADDR, {2'b00, seed[5:0]});
                end else begin
                    rdc(RESULT_HIGH_ADDR, seed[7:0]);
                end
            end
        end
        wrr(PRIMARY_FAULT_ADDR, 8'h80);
        chk({6'h00, oe, irq_n}, 8'h01);
        wsel <= WDOG_80;
        repeat (80010) @(posedge clk);
        chk({7'h0, oe}, 8'h01);
        rdc(SECOND_FAULT_ADDR, 8'h80);
        rdc(SECOND_FAULT_ADDR, 8'h80);
        close_out();
    end

    // ------------------------------------------------------------
    // hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (95000) @(posedge clk);
        error_cnt++;
        close_out();
    end
endmodule // tb_top
`default_nettype wire
